// ===== mdu_pkg.sv
/*
  Constants, register map and types shared by the multiply/divide unit.
  Assumes a single clock domain and a 32-bit Avalon-MM register slave.
*/
// Operation
// - Each operation is load bytes, execute, then read results back.
// - First write of byte 0 resets the unit and starts error tracking.
// - Last write of the loading order starts divide or multiply.
// - Division returns quotient in bytes 0..3, remainder in bytes 4, 5.
// - Last result read returns the unit to ready for the next operation.
// - Multiply returns the 32-bit product in bytes 0..3, low byte first.
// - Control write with zero shift count after bytes 0..3 starts normalize.
// - Normalize stores leading zero count and normalized value back.
// - Control write with nonzero count and direction starts a 32-bit shift.
// - An operand write that breaks or restarts an operation sets the error flag.
// - The error flag clears when an operation completes in proper order.
// - Error tracking runs from first byte 0 write to last result read.
// - Overflow on zero divisor, multiply overflow, or already normalized input.
package mdu_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [5:0] MDU_OFS_BYTE0 = 6'h00;
  localparam logic [5:0] MDU_OFS_BYTE1 = 6'h04;
  localparam logic [5:0] MDU_OFS_BYTE2 = 6'h08;
  localparam logic [5:0] MDU_OFS_BYTE3 = 6'h0c;
  localparam logic [5:0] MDU_OFS_BYTE4 = 6'h10;
  localparam logic [5:0] MDU_OFS_BYTE5 = 6'h14;
  localparam logic [5:0] MDU_OFS_ARITH_CONTROL_REG = 6'h18;
  localparam logic [5:0] MDU_OFS_STAT = 6'h1c;
  localparam logic [5:0] MDU_OFS_MASK = 6'h20;
  // ----------------------------------------
  // Register select codes, fields, reset values
  // ----------------------------------------
  localparam logic [3:0] MDU_SEL_ARITH_CONTROL_REG = 4'h6;
  localparam logic [3:0] MDU_SEL_STAT = 4'h7;
  localparam logic [3:0] MDU_SEL_MASK = 4'h8;
  localparam logic [3:0] MDU_SEL_NONE = 4'hf;
  localparam int MDU_SEF_BIT = 7;
  localparam int MDU_OVF_BIT = 6;
  localparam int MDU_DIR_BIT = 5;
  localparam int MDU_IRQ_DONE = 0;
  localparam int MDU_IRQ_SEF = 1;
  localparam int MDU_IRQ_OVF = 2;
  localparam logic [7:0] MDU_BYTE_RST = 8'h00;
  localparam logic [4:0] MDU_SC_RST = 5'h00;
  localparam logic [2:0] MDU_IRQ_RST = 3'h0;
  localparam logic MDU_WAIT_RST = 1'b1;
  localparam logic [4:0] MDU_SC_MAX = 5'h1f;
  localparam logic [5:0] MDU_DIV32_STEPS = 6'h20;
  localparam logic [5:0] MDU_DIV16_STEPS = 6'h10;
  localparam logic [2:0] MDU_RD_LAST_DIV32 = 3'h5;
  localparam logic [2:0] MDU_RD_LAST = 3'h3;

  typedef enum logic [2:0] {MDU_OP_DIV32, MDU_OP_DIV16, MDU_OP_MUL, MDU_OP_NORM,
                            MDU_OP_SHIFT} mdu_op_t;

  // Address to register select code
  function automatic logic [3:0] mdu_dec(input logic [5:0] a);
    case (a)
      MDU_OFS_BYTE0: mdu_dec = 4'h0;
      MDU_OFS_BYTE1: mdu_dec = 4'h1;
      MDU_OFS_BYTE2: mdu_dec = 4'h2;
      MDU_OFS_BYTE3: mdu_dec = 4'h3;
      MDU_OFS_BYTE4: mdu_dec = 4'h4;
      MDU_OFS_BYTE5: mdu_dec = 4'h5;
      MDU_OFS_ARITH_CONTROL_REG: mdu_dec = MDU_SEL_ARITH_CONTROL_REG;
      MDU_OFS_STAT: mdu_dec = MDU_SEL_STAT;
      MDU_OFS_MASK: mdu_dec = MDU_SEL_MASK;
      default: mdu_dec = MDU_SEL_NONE;
    endcase
  endfunction
endpackage

// ===== mdu_if.sv
/*
  Internal carrier between the register top, sequence tracker and engine.
  Assumes all three parties run on the same clock.
*/
interface mdu_if import mdu_pkg::*; ();
  logic wr_ev;
  logic rd_ev;
  logic [3:0] sel;
  logic sc_zero;
  logic start;
  logic load_rst;
  logic err_set;
  logic err_clr;
  mdu_op_t op;
  mdu_op_t op_cur;
  logic [31:0] opa;
  logic [15:0] opb;
  logic [4:0] sc;
  logic dir;
  logic busy;
  logic done;
  logic ovf;
  logic [31:0] res;
  logic [15:0] rem;
  logic [4:0] res_sc;

  modport top (output wr_ev, rd_ev, sel, sc_zero, opa, opb, sc, dir,
               input start, load_rst, err_set, err_clr, op_cur, busy, done, ovf, res, rem,
               res_sc);
  modport trk (input wr_ev, rd_ev, sel, sc_zero, done,
               output start, load_rst, err_set, err_clr, op, op_cur);
  modport eng (input start, op, opa, opb, sc, dir,
               output busy, done, ovf, res, rem, res_sc);
endinterface

// ===== mdu_arith.sv
/*
  Arithmetic engine: bit-serial divide, single-step multiply, normalize, shift.
  Assumes operands stay stable while busy (the bus is stalled meanwhile).
*/
module mdu_arith import mdu_pkg::*; (
  input logic clk,
  input logic rst,
  mdu_if.eng e
);
  typedef enum logic [1:0] {MDU_E_IDLE, MDU_E_DIV, MDU_E_NORM, MDU_E_SHF} mdu_eng_t;
  mdu_eng_t st_q, st_d;
  mdu_op_t op_q, op_d;
  logic [31:0] acc_q, acc_d;
  logic [15:0] rem_q, rem_d;
  logic [5:0] cnt_q, cnt_d;
  logic [4:0] sc_q, sc_d;
  logic dir_q, dir_d, ovf_q, ovf_d, done_q, done_d;

  // Restoring divide step, unsigned compare
  wire logic [16:0] div_sh = {rem_q, acc_q[31]};
  wire logic [16:0] div_dv = {1'b0, e.opb};
  wire logic div_ge = div_sh >= div_dv;
  wire logic [16:0] div_df = div_sh - div_dv;
  wire logic [31:0] mul_p = {16'h0000, e.opa[15:0]} * {16'h0000, e.opb};

  // Next state; only one operation runs at a time
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    acc_d = acc_q;
    rem_d = rem_q;
    cnt_d = cnt_q;
    sc_d = sc_q;
    dir_d = dir_q;
    ovf_d = ovf_q;
    done_d = 1'b0;
    case (st_q)
      MDU_E_IDLE: begin
        if (e.start) begin
          op_d = e.op;
          acc_d = e.opa;
          rem_d = 16'h0000;
          sc_d = MDU_SC_RST;
          ovf_d = (e.op inside {MDU_OP_DIV32, MDU_OP_DIV16}) && e.opb == 16'h0000;
          case (e.op)
            MDU_OP_DIV32: begin
              cnt_d = MDU_DIV32_STEPS;
              st_d = MDU_E_DIV;
            end
            MDU_OP_DIV16: begin
              acc_d = {e.opa[15:0], 16'h0000};
              cnt_d = MDU_DIV16_STEPS;
              st_d = MDU_E_DIV;
            end
            MDU_OP_MUL: begin
              acc_d = mul_p;
              ovf_d = |mul_p[31:16]; // Product beyond 16 bits
              done_d = 1'b1;
            end
            MDU_OP_NORM: begin
              ovf_d = e.opa[31]; // Already normalized
              st_d = MDU_E_NORM;
            end
            MDU_OP_SHIFT: begin
              sc_d = e.sc;
              dir_d = e.dir;
              st_d = MDU_E_SHF;
            end
            default: st_d = MDU_E_IDLE;
          endcase
        end
      end
      MDU_E_DIV: begin
        acc_d = {acc_q[30:0], div_ge};
        rem_d = div_ge ? div_df[15:0] : div_sh[15:0];
        cnt_d = cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          st_d = MDU_E_IDLE;
          done_d = 1'b1;
        end
      end
      MDU_E_NORM: begin
        // An all-zero value stops at the field limit rather than spinning
        if (acc_q[31] || sc_q == MDU_SC_MAX) begin
          st_d = MDU_E_IDLE;
          done_d = 1'b1;
        end else begin
          acc_d = {acc_q[30:0], 1'b0};
          sc_d = sc_q + 5'h01;
        end
      end
      MDU_E_SHF: begin
        if (sc_q == MDU_SC_RST) begin
          st_d = MDU_E_IDLE;
          done_d = 1'b1;
        end else begin
          acc_d = dir_q ? {1'b0, acc_q[31:1]} : {acc_q[30:0], 1'b0};
          sc_d = sc_q - 5'h01;
        end
      end
      default: st_d = MDU_E_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= MDU_E_IDLE;
      op_q <= MDU_OP_DIV32;
      acc_q <= 32'h0000_0000;
      rem_q <= 16'h0000;
      cnt_q <= 6'h00;
      sc_q <= MDU_SC_RST;
      dir_q <= 1'b0;
      ovf_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      acc_q <= acc_d;
      rem_q <= rem_d;
      cnt_q <= cnt_d;
      sc_q <= sc_d;
      dir_q <= dir_d;
      ovf_q <= ovf_d;
      done_q <= done_d;
    end
  end

  // Busy covers the done cycle so no access races the write-back
  assign e.busy = (st_q != MDU_E_IDLE) | done_q;
  assign e.done = done_q;
  assign e.ovf = ovf_q;
  assign e.res = acc_q;
  assign e.rem = rem_q;
  assign e.res_sc = sc_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence div_zero_go;
    e.start && (e.op inside {MDU_OP_DIV32, MDU_OP_DIV16}) && e.opb == 16'h0000;
  endsequence
  sequence div_flag_up;
    e.done && e.ovf;
  endsequence
  div_zero_ovf_a: assert property (div_zero_go |-> ##[1:33] div_flag_up)
    else $error("zero divisor did not raise overflow");
  mul_product_a: assert property (e.start && e.op == MDU_OP_MUL |=>
    e.done && e.res == $past(mul_p)) else $error("product wrong or late");
  norm_msb_a: assert property (e.done && op_q == MDU_OP_NORM && e.res != 32'h0000_0000
    |-> e.res[31]) else $error("normalized value has leading zero");
  shift_fill_a: assert property (st_q == MDU_E_SHF && sc_q != MDU_SC_RST && !dir_q
    |=> acc_q == {$past(acc_q[30:0]), 1'b0}) else $error("left shift step wrong");
endmodule

// ===== mdu_seq.sv
/*
  Access order tracker: decides when to start, and sets/clears the error flag.
  Assumes one accepted bus access per event pulse, none while the engine runs.
*/
module mdu_seq import mdu_pkg::*; (
  input logic clk,
  input logic rst,
  mdu_if.trk t
);
  typedef enum logic [3:0] {MDU_S_IDLE, MDU_S_B0, MDU_S_B01, MDU_S_B012, MDU_S_B0123,
                            MDU_S_D16, MDU_S_D32, MDU_S_M4, MDU_S_M41, MDU_S_CALC,
                            MDU_S_READ} mdu_seq_t;
  mdu_seq_t st_q, st_d;
  mdu_op_t op_q, op_d, sop;
  logic [2:0] ridx_q, ridx_d;
  logic legal, start;

  // Result register expected at read step idx; 16-bit divide skips bytes 2, 3
  function automatic logic [3:0] exp_reg(input mdu_op_t op, input logic [2:0] idx);
    exp_reg = {1'b0, (op == MDU_OP_DIV16 && idx >= 3'h2) ? 3'(idx + 3'h2) : idx};
  endfunction

  function automatic logic last_rd(input mdu_op_t op, input logic [2:0] idx);
    last_rd = (op == MDU_OP_DIV32) ? idx == MDU_RD_LAST_DIV32 : idx == MDU_RD_LAST;
  endfunction

  wire logic wr_b0 = t.wr_ev && t.sel == 4'h0;
  wire logic rd_ok = t.rd_ev && st_q == MDU_S_READ && t.sel == exp_reg(op_q, ridx_q);

  // Load, execute, read phases
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    ridx_d = ridx_q;
    sop = op_q;
    start = 1'b0;
    legal = 1'b1;
    t.load_rst = 1'b0;
    t.err_set = 1'b0;
    t.err_clr = 1'b0;
    if (wr_b0) begin
      t.load_rst = 1'b1;
      t.err_set = st_q != MDU_S_IDLE; // Restart mid-operation
      st_d = MDU_S_B0;
    end else if (t.wr_ev) begin
      legal = 1'b0;
      case (st_q)
        MDU_S_IDLE: legal = 1'b1; // Untracked outside a sequence
        MDU_S_B0: begin
          legal = t.sel == 4'h1 || t.sel == 4'h4;
          st_d = (t.sel == 4'h1) ? MDU_S_B01 : MDU_S_M4;
        end
        MDU_S_B01: begin
          legal = t.sel == 4'h2 || t.sel == 4'h4;
          st_d = (t.sel == 4'h2) ? MDU_S_B012 : MDU_S_D16;
        end
        MDU_S_B012: begin
          legal = t.sel == 4'h3;
          st_d = MDU_S_B0123;
        end
        MDU_S_B0123: begin
          legal = t.sel == 4'h4 || t.sel == MDU_SEL_ARITH_CONTROL_REG;
          st_d = MDU_S_D32;
          if (t.sel == MDU_SEL_ARITH_CONTROL_REG) begin
            start = 1'b1;
            sop = t.sc_zero ? MDU_OP_NORM : MDU_OP_SHIFT;
          end
        end
        MDU_S_D16, MDU_S_D32, MDU_S_M41: begin
          legal = t.sel == 4'h5;
          start = legal;
          sop = (st_q == MDU_S_D16) ? MDU_OP_DIV16 :
                (st_q == MDU_S_D32) ? MDU_OP_DIV32 : MDU_OP_MUL;
        end
        MDU_S_M4: begin
          legal = t.sel == 4'h1;
          st_d = MDU_S_M41;
        end
        default: legal = 1'b0;
      endcase
      if (start) begin
        op_d = sop;
        st_d = MDU_S_CALC;
      end else if (!legal && t.sel < MDU_SEL_ARITH_CONTROL_REG) begin
        t.err_set = 1'b1; // Out-of-order operand write aborts
        st_d = MDU_S_IDLE;
      end else if (!legal) begin
        st_d = st_q;
      end
    end else if (t.done && st_q == MDU_S_CALC) begin
      st_d = MDU_S_READ;
      ridx_d = 3'h0;
    end else if (rd_ok) begin
      ridx_d = ridx_q + 3'h1;
      if (last_rd(op_q, ridx_q)) begin
        t.err_clr = 1'b1;
        st_d = MDU_S_IDLE; // Ready for the next operation
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= MDU_S_IDLE;
      op_q <= MDU_OP_DIV32;
      ridx_q <= 3'h0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      ridx_q <= ridx_d;
    end
  end

  assign t.start = start;
  assign t.op = sop;
  assign t.op_cur = op_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  first_write_a: assert property (wr_b0 |=> st_q == MDU_S_B0)
    else $error("byte 0 write did not restart tracking");
  mul_start_a: assert property (st_q == MDU_S_M41 && t.wr_ev && t.sel == 4'h5
    |-> t.start && t.op == MDU_OP_MUL) else $error("multiply did not start");
  last_read_a: assert property (t.err_clr |=> st_q == MDU_S_IDLE)
    else $error("last read did not return to ready");
  idle_quiet_a: assert property (st_q == MDU_S_IDLE && t.wr_ev && t.sel != 4'h0
    |-> !t.err_set && !t.start) else $error("write outside a sequence was tracked");
endmodule

// ===== mdu_top.sv
/*
  Multiply/divide unit top: Avalon-MM register slave with waitrequest,
  operand/result bytes, control register, interrupt status and mask.
  Assumes a master that holds each request until waitrequest is low.
*/
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
module mdu_top import mdu_pkg::*; (
  input logic clk,
  input logic rst,
  input logic [5:0] address,
  input logic read,
  input logic write,
  input logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] md_q [6];
  logic [7:0] md_d [6];
  logic [4:0] sc_q, sc_d;
  logic dir_q, dir_d;
  logic sef_q, sef_d;
  logic ovf_q, ovf_d;
  logic [2:0] stat_q, stat_d;
  logic [2:0] mask_q, mask_d;
  logic wait_q, irq_q;
  logic [31:0] rdata_q;

  mdu_if mif ();

  mdu_seq u_seq (
    .clk(clk),
    .rst(rst),
    .t(mif.trk)
  );

  mdu_arith u_arith (
    .clk(clk),
    .rst(rst),
    .e(mif.eng)
  );

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // Waitrequest drops for exactly one cycle per access. Holding it while
  // the engine runs keeps software from touching operands mid-calculation.
  wire logic req = read | write;
  wire logic grant = req & wait_q & ~mif.busy;
  wire logic take = req & ~wait_q;
  wire logic [3:0] sel = mdu_dec(address);
  wire logic sel_md = sel < MDU_SEL_ARITH_CONTROL_REG;
  wire logic wr_arith_control_reg = take & write & (sel == MDU_SEL_ARITH_CONTROL_REG);
  wire logic wr_stat = take & write & (sel == MDU_SEL_STAT);
  wire logic wr_mask = take & write & (sel == MDU_SEL_MASK);
  wire logic wr_b5 = take & write & (sel == 4'h5);
  wire logic [7:0] arith_control_reg_v = {sef_q, ovf_q, dir_q, sc_q};

  // Read mux; unmapped addresses read as zero
  wire logic [31:0] rmux = sel_md ? {24'h0000_00, md_q[sel[2:0]]} :
                           (sel == MDU_SEL_ARITH_CONTROL_REG) ? {24'h0000_00, arith_control_reg_v} :
                           (sel == MDU_SEL_STAT) ? {29'h0000_0000, stat_q} :
                           (sel == MDU_SEL_MASK) ? {29'h0000_0000, mask_q} :
                           32'h0000_0000;

  // Events to the tracker and operands to the engine
  assign mif.wr_ev = take & write;
  assign mif.rd_ev = take & read;
  assign mif.sel = sel;
  assign mif.sc_zero = writedata[4:0] == MDU_SC_RST;
  assign mif.sc = writedata[4:0];
  assign mif.dir = writedata[MDU_DIR_BIT];
  assign mif.opa = {md_q[3], md_q[2], md_q[1], md_q[0]};
  // Byte 5 is bypassed: its own write is what starts divide and multiply
  assign mif.opb = {wr_b5 ? writedata[7:0] : md_q[5], md_q[4]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= MDU_WAIT_RST;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~grant;
      rdata_q <= grant ? rmux : rdata_q;
    end
  end

  // ----------------------------------------
  // Operand and result bytes
  // ----------------------------------------
  // Bus writes and engine write-back never coincide: the bus is stalled
  // during the done cycle.
  wire logic is_div = mif.op_cur inside {MDU_OP_DIV32, MDU_OP_DIV16};

  for (genvar i = 0; i < 6; i++) begin : g_md
    wire logic [7:0] eng_b;
    wire logic eng_hit;
    if (i < 4) begin : g_lo
      assign eng_b = mif.res[8*i +: 8];
      assign eng_hit = mif.done;
    end else begin : g_hi
      assign eng_b = mif.rem[8*(i-4) +: 8]; // Remainder bytes
      assign eng_hit = mif.done & is_div;
    end
    assign md_d[i] = eng_hit ? eng_b :
                     (take & write & (sel == 4'(i))) ? writedata[7:0] : md_q[i];

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        md_q[i] <= MDU_BYTE_RST;
      end else begin
        md_q[i] <= md_d[i];
      end
    end
  end

  // ----------------------------------------
  // Control register and flags
  // ----------------------------------------
  // Normalize overwrites the count with the leading zero total
  wire logic norm_done = mif.done & (mif.op_cur == MDU_OP_NORM);
  wire logic ovf_ev = mif.done & mif.ovf;

  always_comb begin
    sc_d = norm_done ? mif.res_sc : (wr_arith_control_reg ? writedata[4:0] : sc_q);
    dir_d = wr_arith_control_reg ? writedata[MDU_DIR_BIT] : dir_q;
    // Set wins over clear on both flags
    sef_d = mif.err_set ? 1'b1 : (mif.err_clr ? 1'b0 : sef_q);
    ovf_d = ovf_ev ? 1'b1 : ((mif.load_rst | mif.start) ? 1'b0 : ovf_q);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sc_q <= MDU_SC_RST;
      dir_q <= 1'b0;
      sef_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      sc_q <= sc_d;
      dir_q <= dir_d;
      sef_q <= sef_d;
      ovf_q <= ovf_d;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // Sticky events, write one to clear; a new event beats a clear
  wire logic [2:0] irq_ev = {ovf_ev, mif.err_set, mif.done};
  wire logic [2:0] irq_w1c = wr_stat ? writedata[2:0] : MDU_IRQ_RST;

  always_comb begin
    stat_d = (stat_q & ~irq_w1c) | irq_ev;
    mask_d = wr_mask ? writedata[2:0] : mask_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_q <= MDU_IRQ_RST;
      mask_q <= MDU_IRQ_RST;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign irq = irq_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence calc_done;
    mif.done && is_div;
  endsequence
  sequence rem_stored;
    {md_q[5], md_q[4]} == $past(mif.rem);
  endsequence
  wait_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  start_busy_a: assert property (mif.start |=> mif.busy && waitrequest)
    else $error("engine not busy after start");
  div_store_a: assert property (calc_done |=> rem_stored)
    else $error("remainder not stored in bytes 4 and 5");
  err_set_a: assert property (mif.err_set |=> sef_q)
    else $error("sequence error flag not set");
  err_clr_a: assert property (mif.err_clr && !mif.err_set |=> !sef_q)
    else $error("sequence error flag not cleared");
  norm_count_a: assert property (norm_done |=> sc_q == $past(mif.res_sc))
    else $error("normalize count not stored");
  ovf_flag_a: assert property (ovf_ev |=> ovf_q && arith_control_reg_v[MDU_OVF_BIT])
    else $error("overflow flag not set");
endmodule

// ===== tb_top.sv
/*
  Self-checking bench for the multiply/divide unit top, acting as Avalon-MM master.
  Assumes the unit answers each access with one low cycle of waitrequest.
*/
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mdu_pkg::*;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  logic clk, rst, read, write, waitrequest, irq;
  logic [5:0] address;
  logic [31:0] writedata, readdata, q;
  logic [7:0] g [6];
  int err_count, compares;
  mdu_top i_dut(.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq));
  // Clock: 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------
  // One idle edge before each request avoids two drives of a strobe in one step
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    // Waits as long as the unit stalls; only the watchdog ends a hang
    do begin @(posedge clk); end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wrb(input int i, input logic [7:0] v);
    bus(1'b1, 6'(i * 4), {24'h00_0000, v});
  endtask
  task automatic rdb(input int i);
    bus(1'b0, 6'(i * 4), 32'h0000_0000);
    g[i] = q[7:0];
  endtask
  task automatic wr4(input logic [31:0] v);
    for (int i = 0; i < 4; i++) wrb(i, v[i*8 +: 8]);
  endtask
  task automatic rd4(input logic [31:0] e);
    for (int i = 0; i < 4; i++) rdb(i);
    `CHK({g[3], g[2], g[1], g[0]}, e)
  endtask
  task automatic ctl(input logic [7:0] e, input logic [7:0] m);
    bus(1'b0, MDU_OFS_ARITH_CONTROL_REG, 32'h0000_0000);
    `CHK(q[7:0] & m, e)
  endtask
  // Leading zero count and shifted value; a zero operand stops at 31
  function automatic logic [36:0] nrm(input logic [31:0] v);
    int n;
    n = 0;
    while (!v[31] && n < 31) begin v = v << 1; n++; end
    return {n[4:0], v};
  endfunction
  // ----------------------------------------
  // Operations
  // ----------------------------------------
  task automatic mul(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] p;
    p = a * b;
    wrb(0, a[7:0]); wrb(4, b[7:0]); wrb(1, a[15:8]); wrb(5, b[15:8]);
    rd4(p);
    ctl({1'b0, p > 32'h0000_ffff, 6'h00}, 8'hc0);
  endtask
  task automatic div(input logic [31:0] x, input logic [15:0] y, input logic w32);
    logic [31:0] xx;
    xx = w32 ? x : {16'h0000, x[15:0]};
    for (int i = 0; i < 4; i++) if (w32 || i < 2) wrb(i, xx[i*8 +: 8]);
    wrb(4, y[7:0]);
    wrb(5, y[15:8]);
    for (int i = 0; i < 6; i++) if (w32 || i < 2 || i > 3) rdb(i);
    if (y != 16'h0000) begin
      `CHK({g[1], g[0]}, 16'(xx / y))
      if (w32) `CHK({g[3], g[2]}, 16'((xx / y) >> 16))
      `CHK({g[5], g[4]}, 16'(xx % y))
    end
    ctl({1'b0, y == 16'h0000, 6'h00}, 8'hc0);
  endtask
  task automatic nsh(input logic [31:0] v, input logic [4:0] s, input logic d);
    logic [36:0] e;
    e = nrm(v);
    wr4(v);
    bus(1'b1, MDU_OFS_ARITH_CONTROL_REG, {26'h000_0000, d, s});
    if (s == 5'h00) begin
      rd4(e[31:0]);
      ctl({1'b0, v[31], 1'b0, e[36:32]}, 8'hff);
    end else begin
      rd4(d ? v >> s : v << s);
      ctl({2'b00, d, s}, 8'hff);
    end
  endtask
  // ----------------------------------------
  // Verdict and watchdog
  // ----------------------------------------
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Sized well above the few thousand cycles the tests need
  initial begin
    #(100 * 60000);
    err_count++;
    complete_run;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h0000_0000;
    void'($urandom(32'h16c2));
    repeat (3) @(posedge clk);
    `CHK(waitrequest, 1'b1)
    rst <= 1'b0;
    div(32'h1234_5678, 16'h0000, 1'b1);
    mul(16'hffff, 16'hffff);
    nsh(32'h8000_0001, 5'h00, 1'b0);
    nsh(32'h0000_0001, 5'h00, 1'b0);
    nsh(32'h0000_0000, 5'h00, 1'b0);
    for (int k = 0; k < 8; k++) begin
      div($urandom, 16'($urandom | 1), 1'b1);
      div($urandom, 16'($urandom | 1), 1'b0);
      mul(16'($urandom), 16'($urandom >> 24));
      nsh($urandom >> ($urandom % 32), 5'h00, 1'b0);
      nsh($urandom, 5'($urandom % 31 + 1), 1'($urandom));
    end
    // Restart in mid-load flags a sequence error, a clean op then clears it
    wrb(0, 8'h11); wrb(1, 8'h22); wrb(0, 8'h33);
    ctl(8'h80, 8'h80);
    bus(1'b0, MDU_OFS_STAT, 32'h0000_0000);
    `CHK(q[MDU_IRQ_SEF], 1'b1)
    mul(16'h0102, 16'h0304);
    // A divisor byte right after byte 0 breaks the order and aborts tracking
    wrb(0, 8'h44); wrb(5, 8'h55);
    ctl(8'h80, 8'h80);
    // Interrupt: set, masked, unmasked, cleared
    `CHK(irq, 1'b0)
    bus(1'b1, MDU_OFS_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    bus(1'b1, MDU_OFS_STAT, 32'h0000_0007);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    bus(1'b0, MDU_OFS_STAT, 32'h0000_0000);
    `CHK(q[2:0], 3'h0)
    bus(1'b0, 6'h3c, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    complete_run;
  end
endmodule
